// File: hdl/gci_pkg.sv
// Operation
// - group 1 always signals on irq
// - fast_irq_select routes group 0 irq/fiq
// - each interrupt below 32 has its own group bit
// - control bit 0 enables group 0
// - separate bit enables group 1
// - common_binary_point picks group 1 binary point
// - ack_control lets primary ack take group 1
// - bypass disable bits gate bypass forwarding
// - end mode bit, secure and nonsecure copies
// - ids 1020 and 1021 are reserved
// - 1022 on primary ack of group 1
// - 1023 when nothing can be signalled
// - 1022 and 1023 acknowledge nothing
// - group 0 primary, group 1 alias ack
// - alias ack of group 0 gives 1023
// - primary ack of group 1 gives 1022
// - ack_control set acks either group
// - security mismatch returns 1022 or 1023
// - nonsecure ack via nonsecure primary only
// - alias registers answer secure accesses only
// - group 1 alias binary point, ack, end, pending
// - reset: all group 0, fast irq off
// - signal only above mask; zero masks all
`default_nettype none
package gci_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PMASK = 8'h04;
    localparam logic [7:0] OFS_BP0 = 8'h08;
    localparam logic [7:0] OFS_ACK = 8'h0C;
    localparam logic [7:0] OFS_EOI = 8'h10;
    localparam logic [7:0] OFS_TOP = 8'h14;
    localparam logic [7:0] OFS_BP1 = 8'h18;
    localparam logic [7:0] OFS_AACK = 8'h1C;
    localparam logic [7:0] OFS_AEOI = 8'h20;
    localparam logic [7:0] OFS_ATOP = 8'h24;
    localparam logic [7:0] OFS_GROUP = 8'h28;
    localparam logic [7:0] OFS_STAT = 8'h2C;
    // control register field positions
    localparam int CB_G0EN = 0;
    localparam int CB_G1EN = 1;
    localparam int CB_ACK_CONTROL = 2;
    localparam int CB_FIQSEL = 3;
    localparam int CB_COMMON_BINARY_POINT = 4;
    localparam int CB_IRQBYPDIS = 5;
    localparam int CB_FIQBYPDIS = 6;
    localparam int CB_EOIS = 9;
    localparam int CB_EOINS = 10;
    // nonsecure writable control bits
    localparam logic [10:0] CTRL_NS_MASK = 11'h402;
    // reset values
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [7:0] PMASK_RST = 8'h00;
    localparam logic [2:0] BP0_RST = 3'h2;
    localparam logic [2:0] BP1_RST = 3'h3;
    localparam logic [31:0] GROUP_RST = 32'h0000_0000;
    localparam logic [7:0] PRIO_IDLE = 8'hFF;
    // special interrupt ids
    localparam logic [9:0] ID_RSV_LO = 10'h3FC;
    localparam logic [9:0] ID_G1_SPUR = 10'h3FE;
    localparam logic [9:0] ID_NONE = 10'h3FF;
    // whole state of the interface
    typedef struct packed {
        logic [10:0] ctrl;
        logic [7:0] pmask;
        logic [2:0] bp0;
        logic [2:0] bp1;
        logic [31:0] grp;
        logic run_valid;
        logic [7:0] run_prio;
        logic [9:0] run_id;
        logic run_g1;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic irq;
        logic fast_irq_request;
        logic ack_pulse;
        logic [9:0] ack_id;
        logic drop_pulse;
        logic deact_pulse;
        logic [9:0] eoi_id;
        logic byp_irq_m;
        logic byp_irq_s;
        logic byp_fiq_m;
        logic byp_fiq_s;
    } gci_state_t;
    localparam gci_state_t STATE_RST = '{
        ctrl: CTRL_RST, pmask: PMASK_RST, bp0: BP0_RST, bp1: BP1_RST,
        grp: GROUP_RST, run_prio: PRIO_IDLE, default: '0};
endpackage
`default_nettype wire

// File: hdl/gci_cpu_if.sv
// Decided for this implementation: the address map and register access over Wishbone.
`default_nettype none
module gci_cpu_if import gci_pkg::*; #(
    // security option present
    parameter bit SEC_EN = 1'b1
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic bus_secure,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // highest pending interrupt from distributor
    input wire logic top_valid,
    input wire logic [9:0] top_id,
    input wire logic [7:0] top_prio,
    // acknowledge and end notices to distributor
    output logic ack_pulse,
    output logic [9:0] ack_id,
    output logic drop_pulse,
    output logic deact_pulse,
    output logic [9:0] eoi_id,
    // bypass pins
    input wire logic byp_irq,
    input wire logic byp_fiq,
    // processor requests
    output logic irq_out,
    output logic fiq_out,
    // group assignment to distributor
    output logic [31:0] group_assign_regs
);

    // registered state and its next value
    gci_state_t s_q;
    gci_state_t s_d;

    // how the interface decides, in short:
    // the distributor hands over one top pending interrupt per cycle,
    // this block judges whether it may be signalled (mask, group enable,
    // preemption against the running priority) and routes it to irq or fiq;
    // register reads of the ack ports take it only when the port matches
    // its group or ack_control lets the primary port take group 1,
    // otherwise a spurious id comes back and nothing moves;
    // end writes drop the running priority and, unless split, deactivate;
    // only one running level is kept, so nesting is not tracked here
    // spurious ids 1022 and 1023 are decided from the same inputs as a
    // real ack, so software may retry at once and get the right answer
    // through the other port

    // binary point n keeps priority bits [7:n+1] as the group part;
    // point 7 keeps none, so nothing can ever preempt under it;
    // the shift amount wraps at 7, hence the explicit override
    // group priority mask for a binary point
    function automatic logic [7:0] gp_mask(input logic [2:0] bp);
        logic [7:0] m;
        m = 8'hFF << (bp + 3'h1);
        if (bp == 3'h7) begin
            m = 8'h00;
        end
        return m;
    endfunction

    // one decoder serves both ack and top pending reads, so the value
    // a top pending read shows is exactly what an ack would return;
    // g1_port is high for the alias ports and for nonsecure primary reads;
    // order of tests matters: a mask or enable miss wins over a port miss,
    // so a masked group 1 interrupt gives 1023 on the primary port too
    // and software never sees 1022 for something it cannot take
    // ack decision: {takes, returned id}
    function automatic logic [10:0] ack_decode(
        input logic g1_port,
        input logic top_g1,
        input logic ack_control,
        input logic sig,
        input logic [9:0] id
    );
        // mask, enable and preemption all folded into sig
        // nothing of sufficient priority
        if (!sig) begin
            return {1'b0, ID_NONE};
        end
        // group 1 port, group 0 on top
        if (g1_port) begin
            return top_g1 ? {1'b1, id} : {1'b0, ID_NONE};
        end
        // group 0 port
        if (!top_g1 || ack_control) begin
            return {1'b1, id};
        end
        return {1'b0, ID_G1_SPUR};
    endfunction

    // byte lanes not enabled keep their old value
    // merge write data by byte enables
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel
    );
        logic [31:0] r;
        // start from the stored word
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // helper nets of the decision logic, all driven by the two
    // combinational processes below
    // decoded view of the top pending interrupt
    logic top_g1;
    logic top_ok;
    logic [2:0] top_bp;
    logic preempt;
    logic grp_en;
    logic sig;
    logic sig_irq;
    logic sig_fiq;
    logic fwd_irq;
    logic fwd_fiq;
    // bus decode
    logic req;
    logic sec;
    logic g1_port;
    logic [10:0] dec;
    logic [31:0] ctrl_w;
    logic [31:0] pmask_w;
    logic [31:0] rd;
    logic [9:0] wr_id;
    logic [7:0] run_mask;

    // everything here is combinational on the registered state and on the
    // distributor inputs; the request pins are registered one cycle later,
    // so a mask or enable write shows on irq_out or fiq_out one edge after
    // the edge that takes the bus cycle
    // the binary point of the running interrupt follows its own group, so a
    // later change of common_binary_point also moves the running group level
    // priority test and request routing
    always_comb begin
        top_g1 = (top_id < 10'h020) ? s_q.grp[top_id[4:0]] : 1'b0;
        top_ok = top_valid && (top_id < ID_RSV_LO);
        if (top_g1 && !s_q.ctrl[CB_COMMON_BINARY_POINT]) begin
            top_bp = s_q.bp1;
        end else begin
            top_bp = s_q.bp0;
        end
        // with no running interrupt anything unmasked may be signalled
        // preemption against running priority
        run_mask = gp_mask(s_q.run_g1 && !s_q.ctrl[CB_COMMON_BINARY_POINT] ? s_q.bp1 : s_q.bp0);
        if (!s_q.run_valid) begin
            preempt = 1'b1;
        end else begin
            preempt = (top_prio & gp_mask(top_bp)) < (s_q.run_prio & run_mask);
        end
        grp_en = top_g1 ? s_q.ctrl[CB_G1EN] : s_q.ctrl[CB_G0EN];
        sig = top_ok && (top_prio < s_q.pmask) && preempt && grp_en;
        // group 1 never reaches fiq; group 0 goes there only when selected
        // output choice
        sig_fiq = sig && !top_g1 && s_q.ctrl[CB_FIQSEL];
        sig_irq = sig && !sig_fiq;
        // bypass is a fallback path: as soon as either group is enabled the
        // interface owns the request pins and the bypass pins are ignored
        // bypass only when both groups are off
        fwd_irq = !s_q.ctrl[CB_IRQBYPDIS] && !s_q.ctrl[CB_G0EN]
            && !s_q.ctrl[CB_G1EN] && s_q.byp_irq_s;
        fwd_fiq = !s_q.ctrl[CB_FIQBYPDIS] && !s_q.ctrl[CB_G0EN]
            && !s_q.ctrl[CB_G1EN] && s_q.byp_fiq_s;
    end

    // bus timing: a request is taken on the edge where cyc and stb are high
    // and ack is low; ack and read data stand for the following cycle only,
    // and the side effects (ack and drop notices, register writes) land on
    // that same edge; holding stb after ack does not start a second access,
    // since the registered ack blocks the very next edge
    // hazard: the top pending inputs are read at the taking edge, so the
    // distributor must not change them in that cycle if the read value and
    // the ack notice are to name the same interrupt
    // register file and acknowledge logic
    always_comb begin
        s_d = s_q;
        // pulses last one cycle
        s_d.ack_pulse = 1'b0;
        s_d.drop_pulse = 1'b0;
        s_d.deact_pulse = 1'b0;
        s_d.wb_ack = 1'b0;
        s_d.wb_dat = 32'h0000_0000;
        // the bypass pins are asynchronous, two flops before any use
        // bypass synchronisers
        s_d.byp_irq_m = byp_irq;
        s_d.byp_irq_s = s_q.byp_irq_m;
        s_d.byp_fiq_m = byp_fiq;
        s_d.byp_fiq_s = s_q.byp_fiq_m;
        // bypass takes over only with both groups off, see above
        // processor request pins
        s_d.irq = sig_irq || fwd_irq;
        s_d.fast_irq_request = sig_fiq || fwd_fiq;
        // decode helpers get a value on every path before the case
        // one access per bus cycle
        req = wb_cyc && wb_stb && !s_q.wb_ack;
        sec = !SEC_EN || bus_secure;
        g1_port = 1'b0;
        dec = 11'h000;
        rd = 32'h0000_0000;
        wr_id = wb_dat_w[9:0];
        ctrl_w = merge({21'h000000, s_q.ctrl}, wb_dat_w, wb_sel);
        pmask_w = merge({24'h000000, s_q.pmask}, wb_dat_w, wb_sel);
        if (req) begin
            s_d.wb_ack = 1'b1;
            unique case (wb_adr)
                // interface control
                OFS_CTRL: begin
                    // nonsecure side sees and writes only its own bits
                    rd = {21'h000000, s_q.ctrl};
                    if (!sec) begin
                        rd = {21'h000000, s_q.ctrl & CTRL_NS_MASK};
                    end
                    if (wb_we && sec) begin
                        s_d.ctrl = ctrl_w[10:0];
                        if (!SEC_EN) begin
                            s_d.ctrl[CB_EOINS] = ctrl_w[CB_EOIS];
                        end
                    end else if (wb_we) begin
                        s_d.ctrl = (s_q.ctrl & ~CTRL_NS_MASK) | (ctrl_w[10:0] & CTRL_NS_MASK);
                    end
                end
                // priority mask
                OFS_PMASK: begin
                    // zero after reset keeps every interrupt masked
                    rd = {24'h000000, s_q.pmask};
                    if (wb_we) begin
                        s_d.pmask = pmask_w[7:0];
                    end
                end
                // primary binary point
                OFS_BP0: begin
                    // secure view is group 0's point, nonsecure view group 1's
                    if (sec) begin
                        rd = {29'h00000000, s_q.bp0};
                        if (wb_we && wb_sel[0]) begin
                            s_d.bp0 = wb_dat_w[2:0];
                        end
                    end else begin
                        // nonsecure copy is the group 1 point
                        rd = {29'h00000000, s_q.bp1};
                        if (wb_we && wb_sel[0]) begin
                            s_d.bp1 = wb_dat_w[2:0];
                        end
                    end
                end
                OFS_BP1: begin
                    if (sec) begin
                        rd = {29'h00000000, s_q.bp1};
                        if (wb_we && wb_sel[0]) begin
                            s_d.bp1 = wb_dat_w[2:0];
                        end
                    end
                end
                // acknowledge and top pending reads
                OFS_ACK, OFS_AACK, OFS_TOP, OFS_ATOP: begin
                    // top pending reads share the decode but never take
                    // nonsecure primary acts as group 1 port
                    g1_port = (wb_adr == OFS_AACK) || (wb_adr == OFS_ATOP) || !sec;
                    dec = ack_decode(g1_port, top_g1, s_q.ctrl[CB_ACK_CONTROL], sig, top_id);
                    rd = {22'h000000, dec[9:0]};
                    if (!sec && ((wb_adr == OFS_AACK) || (wb_adr == OFS_ATOP))) begin
                        rd = 32'h0000_0000;
                        dec[10] = 1'b0;
                    end
                    if (!wb_we && dec[10] && ((wb_adr == OFS_ACK) || (wb_adr == OFS_AACK))) begin
                        s_d.ack_pulse = 1'b1;
                        s_d.ack_id = top_id;
                        s_d.run_valid = 1'b1;
                        s_d.run_prio = top_prio;
                        s_d.run_id = top_id;
                        s_d.run_g1 = top_g1;
                    end
                end
                // end of interrupt writes
                OFS_EOI, OFS_AEOI: begin
                    // an end that names the wrong id or comes through the
                    // wrong port is dropped silently, the running level stays
                    g1_port = (wb_adr == OFS_AEOI) || !sec;
                    // group must match the port used, or ack_control lets the primary port end group 1
                    if (wb_we && s_q.run_valid && (wr_id == s_q.run_id)
                        && (g1_port == s_q.run_g1 || (s_q.ctrl[CB_ACK_CONTROL] && !g1_port))
                        && !(!sec && wb_adr == OFS_AEOI)) begin
                        s_d.drop_pulse = 1'b1;
                        s_d.eoi_id = wr_id;
                        s_d.run_valid = 1'b0;
                        s_d.run_prio = PRIO_IDLE;
                        if (s_q.run_g1) begin
                            s_d.deact_pulse = !s_q.ctrl[CB_EOINS];
                        end else begin
                            s_d.deact_pulse = !s_q.ctrl[CB_EOIS];
                        end
                    end
                end
                OFS_GROUP: begin
                    // ids above 31 are always group 0
                    if (sec) begin
                        rd = s_q.grp;
                        if (wb_we) begin
                            s_d.grp = merge(s_q.grp, wb_dat_w, wb_sel);
                        end
                    end
                end
                // running state
                OFS_STAT: begin
                    // read only view for debug, no side effects
                    rd = {s_q.irq, s_q.fast_irq_request, 1'b0, s_q.run_valid, s_q.run_g1, 1'b0,
                          s_q.run_id, 8'h00, s_q.run_prio};
                end
                // unmapped reads zero
                default: begin
                    // writes to unmapped offsets are ignored
                    rd = 32'h0000_0000;
                end
            endcase
            s_d.wb_dat = rd;
        end
    end

    // with ce low every field holds, pulses included, so a notice that was
    // high when ce fell is seen again once ce returns; the reset branch
    // loads constants only
    // asynchronous reset loads the reset values at once, clearing the bus and the
    // request pins, so the core sees no request during reset
    // state register, reset to group 0 and irq
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= STATE_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // every port below is a plain copy of a state field, no logic after the
    // flops, so the far side sees clean registered levels
    // outputs straight from flops
    assign wb_ack = s_q.wb_ack;
    assign wb_dat_r = s_q.wb_dat;
    assign ack_pulse = s_q.ack_pulse;
    assign ack_id = s_q.ack_id;
    assign drop_pulse = s_q.drop_pulse;
    assign deact_pulse = s_q.deact_pulse;
    assign eoi_id = s_q.eoi_id;
    assign irq_out = s_q.irq;
    assign fiq_out = s_q.fast_irq_request;
    assign group_assign_regs = s_q.grp;

endmodule
`default_nettype wire

// File: tb/gci_assertions.sv
`default_nettype none
module gci_assertions import gci_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // bus side
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic bus_secure,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    // distributor and core side
    input wire logic [7:0] top_prio,
    input wire logic ack_pulse,
    input wire logic [9:0] ack_id,
    input wire logic drop_pulse,
    input wire logic fiq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // shadow of fast select and mask, from secure writes
    logic fiqsel_q;
    logic [7:0] pmask_q;
    logic wr_sec;
    assign wr_sec = wb_ack && wb_we && bus_secure && wb_sel[0];
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fiqsel_q <= 1'b0;
            pmask_q <= PMASK_RST;
        end else if (wr_sec && wb_adr == OFS_CTRL) begin
            fiqsel_q <= wb_dat_w[CB_FIQSEL];
        end else if (wr_sec && wb_adr == OFS_PMASK) begin
            pmask_q <= wb_dat_w[7:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // request taken, then an ack read answer
    sequence s_taken;
        wb_cyc && wb_stb && ce && !wb_ack;
    endsequence
    sequence s_ack_read;
        wb_ack && !wb_we && (wb_adr == OFS_ACK || wb_adr == OFS_AACK);
    endsequence
    a_bus_answer: assert property (s_taken |=> wb_ack) else $error("bus request not answered");
    a_ack_single: assert property (wb_ack |=> !wb_ack) else $error("bus ack longer than one cycle");
    a_idle_data: assert property (!wb_ack |-> wb_dat_r == 32'h0) else $error("read data outside ack");
    a_spur_quiet: assert property (s_ack_read and wb_dat_r[9:0] >= ID_G1_SPUR |-> !ack_pulse)
        else $error("spurious answer acknowledged");
    a_ack_reply: assert property (ack_pulse |-> s_ack_read and wb_dat_r[9:0] == ack_id)
        else $error("ack pulse without matching read");
    a_ack_reserved: assert property (ack_pulse |-> ack_id < ID_RSV_LO) else $error("reserved id acked");
    a_ack_masked: assert property (ack_pulse |-> $past(top_prio) < pmask_q) else $error("masked id acked");
    a_fiq_select: assert property (fiq_out |-> fiqsel_q) else $error("fast request not selected");
    a_drop_end: assert property (drop_pulse |-> wb_ack && wb_we && (wb_adr == OFS_EOI || wb_adr == OFS_AEOI))
        else $error("drop without end write");
endmodule
bind gci_cpu_if gci_assertions gci_assertions_inst (.mclk, .rst_b, .ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .bus_secure, .wb_dat_r, .wb_ack, .top_prio, .ack_pulse, .ack_id, .drop_pulse, .fiq_out);
`default_nettype wire

// File: tb/gci_core_model.sv
`default_nettype none
module gci_core_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // requests from the interface
    input wire logic irq_out,
    input wire logic fiq_out,
    // new requests the core has seen
    output logic [7:0] irq_cnt,
    output logic [7:0] fiq_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_q, fiq_q;
    // count each rising request level
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {irq_q, fiq_q, irq_cnt, fiq_cnt} <= '0;
        end else begin
            irq_q <= irq_out;
            fiq_q <= fiq_out;
            irq_cnt <= irq_cnt + 8'((irq_out === 1'b1) && !irq_q);
            fiq_cnt <= fiq_cnt + 8'((fiq_out === 1'b1) && !fiq_q);
        end
    end
endmodule
`default_nettype wire

// File: tb/gci_cpu_if_tb.sv
`default_nettype none
module gci_cpu_if_tb import gci_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // bench driven inputs
    logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, byp_fiq = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, bus_secure = 1'b0;
    logic [7:0] wb_adr = 8'h00, top_prio = 8'hFF;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic top_valid = 1'b0, byp_irq = 1'b0;
    logic [9:0] top_id = 10'h000;
    // design outputs
    logic [31:0] wb_dat_r, rd, group_assign_regs;
    logic wb_ack, ack_pulse, drop_pulse, deact_pulse, irq_out, fiq_out;
    logic [9:0] ack_id, eoi_id;
    logic [7:0] irq_cnt, fiq_cnt;
    int miscompares = 0, cmp_count = 0, acks = 0, drops = 0, deacts = 0;
    initial forever #2.5 mclk = ~mclk;
    gci_cpu_if gci_cpu_if_inst (.mclk, .rst_b, .ce, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w,
        .bus_secure, .wb_dat_r, .wb_ack, .top_valid, .top_id, .top_prio, .ack_pulse, .ack_id, .drop_pulse,
        .deact_pulse, .eoi_id, .byp_irq, .byp_fiq, .irq_out, .fiq_out, .group_assign_regs);
    gci_core_model gci_core_model_inst (.mclk, .rst_b, .irq_out, .fiq_out, .irq_cnt, .fiq_cnt);
    // count acknowledge and drop notices
    always @(posedge mclk) begin
        acks <= acks + int'(ack_pulse === 1'b1);
        drops <= drops + int'(drop_pulse === 1'b1);
        deacts <= deacts + int'(deact_pulse === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic [7:0] a, input logic we, input logic sec, input logic [31:0] d);
        {wb_cyc, wb_stb, wb_we, bus_secure} <= {2'b11, we, sec};
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat_w <= d;
        @(posedge mclk);
        // only the watchdog ends a wait that never sees ack
        while (wb_ack !== 1'b1) begin
            @(posedge mclk);
        end
        rd = wb_dat_r;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
        @(posedge mclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic sec, input logic [31:0] exp);
        xfer(a, 1'b0, sec, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #5000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rdchk("ctrl", OFS_CTRL, 1'b1, 32'h0);
        rdchk("group", OFS_GROUP, 1'b1, 32'h0);
        rdchk("bp1", OFS_BP1, 1'b1, 32'(BP1_RST));
        // group 0 pending, mask still closed
        top_valid <= 1'b1;
        top_id <= 10'h005;
        top_prio <= 8'h10;
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'h1);
        rdchk("masked ack", OFS_ACK, 1'b1, 32'(ID_NONE));
        xfer(OFS_PMASK, 1'b1, 1'b1, 32'h80);
        repeat (2) @(posedge mclk);
        chk("irq g0", irq_out, 32'h1);
        chk("fiq g0", fiq_out, 32'h0);
        chk("core irq", irq_cnt, 32'h1);
        rdchk("alias ack g0", OFS_AACK, 1'b1, 32'(ID_NONE));
        rdchk("top g0", OFS_TOP, 1'b1, 32'h5);
        rdchk("ack g0", OFS_ACK, 1'b1, 32'h5);
        xfer(OFS_EOI, 1'b1, 1'b1, 32'h5);
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'h9);
        repeat (2) @(posedge mclk);
        chk("fiq sel", fiq_out, 32'h1);
        chk("core fiq", fiq_cnt, 32'h1);
        // group 1 kept below group 0 priority
        top_id <= 10'h007;
        top_prio <= 8'h40;
        xfer(OFS_GROUP, 1'b1, 1'b1, 32'h80);
        chk("group pins", group_assign_regs, 32'h80);
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'hB);
        repeat (2) @(posedge mclk);
        chk("irq g1", irq_out, 32'h1);
        chk("fiq g1", fiq_out, 32'h0);
        rdchk("primary ack g1", OFS_ACK, 1'b1, 32'(ID_G1_SPUR));
        rdchk("ns ack g1", OFS_ACK, 1'b0, 32'h7);
        xfer(OFS_EOI, 1'b1, 1'b0, 32'h7);
        rdchk("ns alias", OFS_AACK, 1'b0, 32'h0);
        rdchk("alias ack g1", OFS_AACK, 1'b1, 32'h7);
        xfer(OFS_AEOI, 1'b1, 1'b1, 32'h7);
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'hF);
        rdchk("ack_control g1", OFS_ACK, 1'b1, 32'h7);
        xfer(OFS_EOI, 1'b1, 1'b1, 32'h7);
        chk("drops", drops, 32'h4);
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq g1 off", irq_out, 32'h0);
        rdchk("ack g1 off", OFS_AACK, 1'b1, 32'(ID_NONE));
        xfer(OFS_GROUP, 1'b1, 1'b1, 32'h0);
        rdchk("ns ack g0", OFS_ACK, 1'b0, 32'(ID_NONE));
        top_id <= ID_RSV_LO;
        rdchk("reserved", OFS_ACK, 1'b1, 32'(ID_NONE));
        chk("acks", acks, 32'h4);
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'h201);
        rdchk("end mode", OFS_CTRL, 1'b1, 32'h201);
        rdchk("end mode ns", OFS_CTRL, 1'b0, 32'h0);
        // split end mode: drop without deactivation
        top_id <= 10'h005;
        rdchk("split ack", OFS_ACK, 1'b1, 32'h5);
        xfer(OFS_EOI, 1'b1, 1'b1, 32'h5);
        chk("split deact", deacts, 32'h4);
        chk("end id", eoi_id, 32'h5);
        rdchk("unmapped", 8'h30, 1'b1, 32'h0);
        // bypass with both groups off
        top_valid <= 1'b0;
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'h0);
        byp_irq <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("bypass on", irq_out, 32'h1);
        xfer(OFS_CTRL, 1'b1, 1'b1, 32'h20);
        repeat (4) @(posedge mclk);
        chk("bypass off", irq_out, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
